// File: design/ais_sequencer.sv
// What this block does
// - index cycle latch sets from its control latch at gate phase B
// - ring position one sets in instruction cycle, indexing, no word mark, step 5 or 10
// - during readout the tens digit of register address is the computed location divided by ten
// - at ring positions one to five the units digit is that location modulo ten
// - upper positions of the register address are always zero
// - first address select rises when indexing and instruction step is 5
// - address double operations also raise the second address select
// - C address register (D address register for B field indexing) reads out from phase B to last gate each cycle
// - true index start rises at ring position two with plus sign on B channel
// - B channel digit sign chooses true or complement addition
// - ring positions two to five request another index cycle
// - indexed first address digits go into the first operand register, the last at ring position six
// - C cycle control sets at ring six with instruction step 5
// - the C cycle after indexing is the normal read-out C cycle
// - B field indexing sets D cycle control at ring six and step 10
// - address double operations load the result into first, second and saved registers
// - four zone tag bits weigh 8 4 2 1 naming register 1 to 15; zero none
// - fifteen five digit registers start at location 25, five locations apart
// - five index cycles add units first; instruction ring holds meanwhile
// - carry out of the top digit is dropped, no overflow indication
`timescale 1ns/10ps
`default_nettype none

module ais_sequencer
  import ais_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        i_cycle,
  input  wire logic [3:0]  iring_step,
  input  wire logic        gate_phase_a,
  input  wire logic        gate_phase_b,
  input  wire logic        gate_last,
  input  wire logic        hund_tag_b,
  input  wire logic        hund_tag_a,
  input  wire logic        tens_tag_b,
  input  wire logic        tens_tag_a,
  input  wire logic        addr_double_op,
  input  wire logic        b_word_mark,
  input  wire logic        b_sign_plus,
  input  wire logic [3:0]  b_digit,
  input  wire logic [19:0] c_addr,
  input  wire logic [19:0] d_addr,
  input  wire logic        wrbk_done,
  output logic             index_required,
  output logic             iring_hold,
  output logic             index_reg_address_readout,
  output logic             mem_read_q,
  output logic      [19:0] mem_addr_q,
  output logic             first_addr_index_select,
  output logic             second_addr_index_select,
  output logic             index_cycle,
  output logic      [2:0]  ring_q,
  output logic             c_readout_q,
  output logic             d_readout_q,
  output logic             start_true_index,
  output logic             true_add_b_q,
  output logic      [19:0] first_operand_addr_reg,
  output logic      [19:0] second_addr_reg,
  output logic      [19:0] saved_second_addr_reg,
  output logic             c_cycle_ctrl,
  output logic             d_cycle_ctrl
);

  ais_state_t state_q;
  ais_state_t state_d;

  logic [3:0] reg_num;
  logic       step_a;
  logic       step_b;
  logic       start_x;
  logic       phase_b_hit;
  logic       cycle_end;
  logic       ring_more;
  logic       ring_final;
  logic       field_b_q;
  logic       double_q;
  logic [6:0] loc;
  logic [6:0] loc_tens;
  logic [6:0] loc_units;
  logic [2:0] ring_d;
  logic [2:0] dig_idx;
  logic [19:0] src_addr;
  logic [3:0] a_digit;
  logic [3:0] sum_digit;
  logic       carry_out;
  logic       carry_q;
  logic       carry_in;
  logic       complement;
  logic       dig_we;
  logic       first_we;
  logic       second_we;
  logic       saved_we;
  logic [3:0] first_dig_q [DIGITS];
  logic [3:0] second_dig_q [DIGITS];
  logic [3:0] saved_dig_q [DIGITS];

  assign reg_num        = {hund_tag_b, hund_tag_a, tens_tag_b, tens_tag_a};
  assign index_required = (reg_num != 4'h0);
  assign step_a         = (iring_step == IRING_STEP_A);
  assign step_b         = (iring_step == IRING_STEP_B);

  assign first_addr_index_select  = index_required && step_a;
  assign second_addr_index_select = index_required && (step_b || (step_a && addr_double_op));

  // a tagless address never leaves idle, so read-out runs on untouched
  assign start_x = (state_q == ST_IDLE) && i_cycle && index_required && !b_word_mark
                   && (step_a || step_b);

  assign index_reg_address_readout = (state_q == ST_XCTRL);
  assign index_cycle  = (state_q == ST_XCYC);
  assign phase_b_hit  = (state_q == ST_XCTRL) && gate_phase_b;
  assign cycle_end    = index_cycle && gate_last;
  assign ring_more    = (ring_q >= RING_UNITS) && (ring_q <= RING_LAST_READ);
  assign ring_final   = (ring_q == RING_FINAL);

  // the ring holds the instruction ring for the whole indexing run and its write back
  assign iring_hold   = (state_q != ST_IDLE) || start_x;

  assign c_cycle_ctrl = (state_q == ST_WRBK) && !field_b_q;
  assign d_cycle_ctrl = (state_q == ST_WRBK) && field_b_q;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (start_x)
          state_d = ST_XCTRL;
      end
      ST_XCTRL:
      begin
        if (gate_phase_b)
          state_d = ST_XCYC;
      end
      ST_XCYC:
      begin
        if (gate_last && ring_more)
          state_d = ST_XCTRL;
        else if (gate_last && ring_final)
          state_d = ST_WRBK;
      end
      ST_WRBK:
      begin
        if (wrbk_done)
          state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // the ring advances at phase B, so position p reads register digit p and adds digit p-1
  assign ring_d = start_x ? RING_FIRST :
                  phase_b_hit ? (ring_q + RING_STEP) :
                  ((state_q == ST_WRBK) && wrbk_done) ? RING_OFF : ring_q;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      ring_q <= RING_OFF;
    else
      ring_q <= ring_d;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      field_b_q <= 1'b0;
      double_q  <= 1'b0;
    end
    else if (start_x)
    begin
      field_b_q <= step_b;
      double_q  <= addr_double_op && step_a;
    end
  end

  // location = first + stride * (register - 1) + (ring - 1), below 100 at ring positions one to five
  assign loc       = IR_FIRST_LOC + 7'(IR_STRIDE * ({3'h0, reg_num} - IR_ONE))
                     + ({4'h0, ring_q} - IR_ONE);
  assign loc_tens  = loc / IR_TEN;
  assign loc_units = loc % IR_TEN;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mem_addr_q <= ADDR_ZERO;
      mem_read_q <= 1'b0;
    end
    else
    begin
      mem_read_q <= index_reg_address_readout && gate_phase_a;
      if (index_reg_address_readout && gate_phase_a)
        mem_addr_q <= {ADDR_HIGH_ZERO, loc_tens[3:0], loc_units[3:0]};
    end
  end

  // address register readout spans phase B to the last gate of each index cycle
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      c_readout_q <= 1'b0;
      d_readout_q <= 1'b0;
    end
    else if (phase_b_hit)
    begin
      c_readout_q <= !field_b_q;
      d_readout_q <= field_b_q;
    end
    else if (cycle_end)
    begin
      c_readout_q <= 1'b0;
      d_readout_q <= 1'b0;
    end
  end

  assign dig_idx  = (ring_q >= RING_UNITS) && (ring_q <= RING_FINAL) ? (ring_q - RING_UNITS) : 3'h0;
  assign src_addr = field_b_q ? d_addr : c_addr;
  assign a_digit  = src_addr[{dig_idx, 2'b00} +: DIGIT_W];

  assign start_true_index = index_cycle && (ring_q == RING_UNITS) && b_sign_plus;
  // only the units sign counts; it is held for the higher digits
  assign complement = (ring_q == RING_UNITS) ? !b_sign_plus : !true_add_b_q;
  assign carry_in   = (ring_q == RING_UNITS) ? complement : carry_q;

  ais_digit_adder u_adder
  (
    .addend_a   (a_digit),
    .addend_b   (b_digit),
    .carry_in   (carry_in),
    .complement (complement),
    .sum        (sum_digit),
    .carry_out  (carry_out)
  );

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      true_add_b_q <= 1'b1;
      carry_q      <= 1'b0;
    end
    else if (cycle_end)
    begin
      if (ring_q == RING_UNITS)
        true_add_b_q <= b_sign_plus;
      // the top carry is simply dropped, nothing flags it
      carry_q <= ring_final ? 1'b0 : carry_out;
    end
  end

  assign dig_we = cycle_end;
  assign first_we  = dig_we && !field_b_q;
  assign second_we = dig_we && (field_b_q || double_q);
  assign saved_we  = dig_we && double_q;

  genvar g;
  generate
    for (g = 0; g < DIGITS; g++)
    begin : g_dig
      logic hit;

      assign hit = (dig_idx == 3'(g));

      always_ff @(posedge clock or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          first_dig_q[g]  <= DIGIT_ZERO;
          second_dig_q[g] <= DIGIT_ZERO;
          saved_dig_q[g]  <= DIGIT_ZERO;
        end
        else
        begin
          if (first_we && hit)
            first_dig_q[g] <= sum_digit;
          if (second_we && hit)
            second_dig_q[g] <= sum_digit;
          if (saved_we && hit)
            saved_dig_q[g] <= sum_digit;
        end
      end

      assign first_operand_addr_reg[g*DIGIT_W +: DIGIT_W] = first_dig_q[g];
      assign second_addr_reg[g*DIGIT_W +: DIGIT_W]        = second_dig_q[g];
      assign saved_second_addr_reg[g*DIGIT_W +: DIGIT_W]  = saved_dig_q[g];
    end
  endgenerate

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  property p_xcyc_phase_b;
    $rose(index_cycle) |-> $past(gate_phase_b) && $past(index_reg_address_readout);
  endproperty
  a_xcyc_phase_b: assert property (p_xcyc_phase_b) else $error("index cycle began off phase B");

  property p_ring_first;
    start_x |=> (ring_q == RING_FIRST) && index_reg_address_readout;
  endproperty
  a_ring_first: assert property (p_ring_first) else $error("ring did not start at one");

  property p_reg_addr;
    index_reg_address_readout && gate_phase_a |=>
      mem_read_q && (mem_addr_q[19:8] == ADDR_HIGH_ZERO)
      && (mem_addr_q[7:0] == {$past(loc_tens[3:0]), $past(loc_units[3:0])});
  endproperty
  a_reg_addr: assert property (p_reg_addr) else $error("index register address wrong");

  property p_double_sel;
    first_addr_index_select && addr_double_op |-> second_addr_index_select;
  endproperty
  a_double_sel: assert property (p_double_sel) else $error("second select missing");

  property p_c_readout;
    index_cycle && !field_b_q && !$rose(index_cycle) |-> c_readout_q && !d_readout_q;
  endproperty
  a_c_readout: assert property (p_c_readout) else $error("C readout not held");

  property p_next_cycle;
    cycle_end && ring_more |=> index_reg_address_readout ##[1:1000] index_cycle;
  endproperty
  a_next_cycle: assert property (p_next_cycle) else $error("no further index cycle");

  property p_c_ctrl;
    cycle_end && ring_final && !field_b_q |=> c_cycle_ctrl && !d_cycle_ctrl && iring_hold;
  endproperty
  a_c_ctrl: assert property (p_c_ctrl) else $error("C cycle control not set");

  property p_d_ctrl;
    cycle_end && ring_final && field_b_q |=> d_cycle_ctrl && !c_cycle_ctrl;
  endproperty
  a_d_ctrl: assert property (p_d_ctrl) else $error("D cycle control not set");

  property p_hold;
    (ring_q != RING_OFF) |-> iring_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("instruction ring not held");

  property p_no_tag;
    (state_q == ST_IDLE) && !index_required |=> (ring_q == RING_OFF) && !index_reg_address_readout;
  endproperty
  a_no_tag: assert property (p_no_tag) else $error("indexing started without a tag");

endmodule

`default_nettype wire

// File: design/ais_pkg.sv
package ais_pkg;

  localparam int unsigned DIGITS  = 5;
  localparam int unsigned DIGIT_W = 4;
  localparam int unsigned ADDR_W  = 20;

  // instruction ring steps at which the units digit of an address has been read in
  localparam logic [3:0] IRING_STEP_A = 4'h5;
  localparam logic [3:0] IRING_STEP_B = 4'hA;

  // indexing ring positions, 0 means the ring is off
  localparam logic [2:0] RING_OFF        = 3'h0;
  localparam logic [2:0] RING_FIRST      = 3'h1;
  localparam logic [2:0] RING_UNITS      = 3'h2;
  localparam logic [2:0] RING_LAST_READ  = 3'h5;
  localparam logic [2:0] RING_FINAL      = 3'h6;
  localparam logic [2:0] RING_STEP       = 3'h1;

  // index register storage map
  localparam logic [6:0] IR_FIRST_LOC  = 7'h19;
  localparam logic [6:0] IR_STRIDE     = 7'h05;
  localparam logic [6:0] IR_ONE        = 7'h01;
  localparam logic [6:0] IR_TEN        = 7'h0A;
  localparam logic [11:0] ADDR_HIGH_ZERO = 12'h000;

  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [4:0] BCD_TEN  = 5'h0A;
  localparam logic [3:0] DIGIT_ZERO = 4'h0;
  localparam logic [19:0] ADDR_ZERO = 20'h00000;

  typedef enum logic [3:0]
  {
    ST_IDLE = 4'h1,
    ST_XCTRL = 4'h2,
    ST_XCYC = 4'h4,
    ST_WRBK = 4'h8
  } ais_state_t;

endpackage

// File: design/ais_digit_adder.sv
`timescale 1ns/10ps
`default_nettype none

module ais_digit_adder
  import ais_pkg::*;
(
  input  wire logic [3:0] addend_a,
  input  wire logic [3:0] addend_b,
  input  wire logic       carry_in,
  input  wire logic       complement,
  output logic      [3:0] sum,
  output logic            carry_out
);

  logic [3:0] b_eff;
  logic [4:0] raw;
  logic [4:0] wrapped;

  // nines complement plus an initial carry gives tens complement subtraction
  assign b_eff     = complement ? (BCD_NINE - addend_b) : addend_b;
  assign raw       = {1'b0, addend_a} + {1'b0, b_eff} + {4'h0, carry_in};
  assign carry_out = (raw >= BCD_TEN);
  assign wrapped   = raw - BCD_TEN;
  assign sum       = carry_out ? wrapped[3:0] : raw[3:0];

endmodule

`default_nettype wire

// File: dv/ais_store_model.sv
`timescale 1ns/10ps
`default_nettype none

module ais_store_model
#(
  parameter int WB_WAIT = 2
)
(
  input  wire logic        clock,
  input  wire logic        mem_read_q,
  input  wire logic [19:0] mem_addr_q,
  input  wire logic        c_cycle_ctrl,
  input  wire logic        d_cycle_ctrl,
  output logic       [3:0] b_digit,
  output logic             b_sign_plus,
  output logic             wrbk_done
);
  // bit 4 set means minus; only the units sign matters to indexing
  logic      [4:0] mem [0:99];
  int              cnt;
  wire logic [6:0] loc;

  assign loc = 7'(mem_addr_q[7:4] * 10 + mem_addr_q[3:0]);

  initial
  begin
    for (int i = 0; i < 100; i++)
      mem[i] = {((i / 5) % 2 == 0), 4'((i * 7 + 3) % 10)};
    b_digit = 4'h0;
    b_sign_plus = 1'b1;
    wrbk_done = 1'b0;
    cnt = 0;
  end

  always @(posedge clock)
  begin
    if (mem_read_q)
    begin
      b_digit <= mem[loc][3:0];
      b_sign_plus <= ~mem[loc][4];
    end
    // write back takes a few cycles, as a real storage cycle would
    if ((c_cycle_ctrl || d_cycle_ctrl) && !wrbk_done && cnt == WB_WAIT)
    begin
      wrbk_done <= 1'b1;
      cnt <= 0;
    end
    else
    begin
      wrbk_done <= 1'b0;
      cnt <= (c_cycle_ctrl || d_cycle_ctrl) ? cnt + 1 : 0;
    end
  end
endmodule

`default_nettype wire

// File: dv/ais_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none

module ais_sequencer_tb
  import ais_pkg::*;
();
  logic        clock, sys_rst, i_cycle, gate_phase_a, gate_phase_b, gate_last;
  logic        hund_tag_b, hund_tag_a, tens_tag_b, tens_tag_a, addr_double_op;
  logic        b_word_mark, b_sign_plus, wrbk_done;
  logic [3:0]  iring_step, b_digit;
  logic [19:0] c_addr, d_addr, mem_addr_q;
  logic        index_required, iring_hold, index_reg_address_readout, mem_read_q;
  logic        first_addr_index_select, second_addr_index_select, index_cycle;
  logic [2:0]  ring_q;
  logic        c_readout_q, d_readout_q, start_true_index, true_add_b_q;
  logic [19:0] first_operand_addr_reg, second_addr_reg, saved_second_addr_reg;
  logic        c_cycle_ctrl, d_cycle_ctrl;
  int          miscompares;
  int          check_count;

  ais_sequencer uut (
    .clock, .sys_rst, .i_cycle, .iring_step, .gate_phase_a, .gate_phase_b,
    .gate_last, .hund_tag_b, .hund_tag_a, .tens_tag_b, .tens_tag_a,
    .addr_double_op, .b_word_mark, .b_sign_plus, .b_digit, .c_addr, .d_addr,
    .wrbk_done, .index_required, .iring_hold, .index_reg_address_readout,
    .mem_read_q, .mem_addr_q, .first_addr_index_select, .second_addr_index_select,
    .index_cycle, .ring_q, .c_readout_q, .d_readout_q, .start_true_index,
    .true_add_b_q, .first_operand_addr_reg, .second_addr_reg,
    .saved_second_addr_reg, .c_cycle_ctrl, .d_cycle_ctrl
  );

  ais_store_model #(.WB_WAIT(2)) u_store (
    .clock, .mem_read_q, .mem_addr_q, .c_cycle_ctrl, .d_cycle_ctrl,
    .b_digit, .b_sign_plus, .wrbk_done
  );

  always #2.5 clock = ~clock;

  task automatic close_out();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic int to_int(input logic [19:0] v);
    int r;
    r = 0;
    for (int k = 4; k >= 0; k--)
      r = r * 10 + int'(v[k*4 +: 4]);
    return r;
  endfunction

  function automatic logic [19:0] to_bcd(input int v);
    logic [19:0] r;
    for (int k = 0; k < 5; k++)
    begin
      r[k*4 +: 4] = 4'(v % 10);
      v = v / 10;
    end
    return r;
  endfunction

  // tags name register n; inputs held four cycles while the ring is checked three times to stay off
  task automatic hold_request(input int n, input logic wm, input logic [3:0] step);
    @(posedge clock);
    {hund_tag_b, hund_tag_a, tens_tag_b, tens_tag_a} <= 4'(n);
    iring_step <= step;
    b_word_mark <= wm;
    i_cycle <= 1'b1;
    repeat (3)
    begin
      @(posedge clock);
      #1;
      check(20'(ring_q), 20'h0);
    end
    check(20'(iring_hold), 20'(n != 0 && !wm));
    check(20'(index_required), 20'(n != 0));
    @(posedge clock);
    i_cycle <= 1'b0;
    b_word_mark <= 1'b0;
  endtask

  task automatic run_index(input int n, input logic [3:0] step, input logic dbl);
    int   loc, idx, res, k;
    logic plus, fa;
    loc = 25 + 5 * (n - 1);
    idx = 0;
    for (k = 4; k >= 0; k--)
      idx = idx * 10 + int'(u_store.mem[loc + k][3:0]);
    plus = ~u_store.mem[loc][4];
    fa = (step == IRING_STEP_A);
    res = to_int(fa ? c_addr : d_addr);
    res = plus ? (res + idx) % 100000 : (res + 100000 - idx) % 100000;
    @(posedge clock);
    {hund_tag_b, hund_tag_a, tens_tag_b, tens_tag_a} <= 4'(n);
    iring_step <= step;
    addr_double_op <= dbl;
    i_cycle <= 1'b1;
    #1;
    check(20'(first_addr_index_select), 20'(fa));
    check(20'(second_addr_index_select), 20'(!fa || dbl));
    @(posedge clock);
    i_cycle <= 1'b0;
    #1;
    check(20'(ring_q), 20'h1);
    check(20'(index_reg_address_readout), 20'h1);
    for (int p = 1; p <= 5; p++)
    begin
      @(posedge clock);
      gate_phase_a <= 1'b1;
      @(posedge clock);
      gate_phase_a <= 1'b0;
      #1;
      check(20'(mem_read_q), 20'h1);
      check(mem_addr_q, {12'h000, 4'((loc + p - 1) / 10), 4'((loc + p - 1) % 10)});
      @(posedge clock);
      gate_phase_b <= 1'b1;
      @(posedge clock);
      gate_phase_b <= 1'b0;
      #1;
      check(20'(index_cycle), 20'h1);
      check(20'(ring_q), 20'(p + 1));
      check(20'(start_true_index), 20'(p == 1 && plus));
      check(20'({c_readout_q, d_readout_q}), 20'({fa, !fa}));
      check(20'(iring_hold), 20'h1);
      @(posedge clock);
      gate_last <= 1'b1;
      @(posedge clock);
      gate_last <= 1'b0;
    end
    #1;
    check(20'({c_cycle_ctrl, d_cycle_ctrl}), 20'({fa, !fa}));
    k = 0;
    while (wrbk_done !== 1'b1 && k < 20)
    begin
      @(posedge clock);
      #1;
      k++;
    end
    if (k == 20)
    begin
      miscompares++;
      close_out();
    end
    @(posedge clock);
    #1;
    check(20'(ring_q), 20'h0);
    if (fa)
      check(first_operand_addr_reg, to_bcd(res));
    if (!fa || dbl)
      check(second_addr_reg, to_bcd(res));
    if (fa && dbl)
      check(saved_second_addr_reg, to_bcd(res));
    check(20'(true_add_b_q), 20'(plus));
  endtask

  task automatic sweep_registers();
    for (int n = 1; n <= 15; n++)
      run_index(n, n[0] ? IRING_STEP_A : IRING_STEP_B, (n % 3) == 0);
  endtask

  initial
  begin
    {clock, i_cycle, gate_phase_a, gate_phase_b, gate_last, addr_double_op} = '0;
    {hund_tag_b, hund_tag_a, tens_tag_b, tens_tag_a, b_word_mark} = '0;
    iring_step = 4'h0;
    c_addr = 20'h99990;
    d_addr = 20'h01234;
    miscompares = 0;
    check_count = 0;
    sys_rst = 1'b1;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    check(20'(true_add_b_q), 20'h1);
    hold_request(0, 1'b0, IRING_STEP_A);
    hold_request(1, 1'b1, IRING_STEP_A);
    sweep_registers();
    @(posedge clock);
    c_addr <= 20'h00007;
    #1;
    run_index(2, IRING_STEP_A, 1'b1);
    close_out();
  end
endmodule

`default_nettype wire
